// *** rsr_pkg.sv ***
// Package for the reset and stop-recovery sequencer: timing, register map, field layout.
// Assumes a single 250 MHz system clock and a 32-bit AHB-Lite register port.
package rsr_pkg;

    localparam int CLK_PERIOD_NS = 4;

    // Least times, rounded up to whole cycles
    localparam int RST_TIMEOUT_NS = 1000;
    localparam int POR_DELAY_NS   = 2000;
    localparam logic [12:0] RST_TIMEOUT_CYC =
        13'((RST_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [12:0] POR_DELAY_CYC =
        13'((POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Oscillator period, rounded down to whole cycles of the system clock
    localparam int IPO_PERIOD_NS = 180;
    localparam logic [7:0] IPO_DIV_CYC = 8'(IPO_PERIOD_NS / CLK_PERIOD_NS);

    // Stop-recovery hold, in oscillator cycles
    localparam logic [12:0] SMR_FAST_IPO = 13'h0042;
    localparam int          SMR_SLOW_IPO = 5000;

    // Consecutive low samples that make an external reset
    localparam logic [1:0] EXT_FILTER_CYC = 2'h3;

    // Register byte offsets
    localparam logic [7:0] ADDR_CAUSE  = 8'h00;
    localparam logic [7:0] ADDR_MASK   = 8'h04;
    localparam logic [7:0] ADDR_DBG    = 8'h08;
    localparam logic [7:0] ADDR_OSC    = 8'h0C;
    localparam logic [7:0] ADDR_PINCFG = 8'h10;
    localparam logic [7:0] ADDR_STATE  = 8'h14;

    // reset_cause_register fields
    localparam int CAUSE_W   = 5;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_EXT = 1;
    localparam int CAUSE_WDT = 2;
    localparam int CAUSE_BO  = 3;
    localparam int CAUSE_SMR = 4;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h00;
    localparam logic [CAUSE_W-1:0] MASK_RESET  = 5'h00;

    // oscillator_config_register fields
    localparam int OSC_W       = 4;
    localparam int OSC_IPO_EN  = 0;
    localparam int OSC_XTAL_EN = 1;
    localparam int OSC_SEL_LO  = 2;
    localparam logic [1:0]       CLKSEL_IPO = 2'h0;
    localparam logic [OSC_W-1:0] OSC_RESET  = 4'h1;

    // Debug control and pin configuration bits
    localparam int DBG_RST_REQ   = 0;
    localparam int PINCFG_DRIVE  = 0;

    typedef enum logic [1:0] {
        RSR_RUN,
        RSR_RESET,
        RSR_STOP,
        RSR_RECOVER
    } rsr_state_t;

endpackage

// *** rsr_sync2.sv ***
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the idle level of the input is high (reset pin released).
`timescale 1ns/10ps
`default_nettype none
module rsr_sync2 (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // rsr_sync2
`default_nettype wire

// *** rsr_delay_cnt.sv ***
// Loadable down counter for reset and recovery hold times.
// Assumes tick is a one-cycle enable at the counting rate.
`timescale 1ns/10ps
`default_nettype none
module rsr_delay_cnt (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        load,
    input  wire logic [12:0] load_val,
    input  wire logic        tick,
    output logic             busy
);
    logic [12:0] cnt_ff;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_ff <= 13'h0000;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (tick && (cnt_ff != 13'h0000)) begin
            cnt_ff <= cnt_ff - 13'h0001;
        end
    end

    assign busy = (cnt_ff != 13'h0000);
endmodule // rsr_delay_cnt
`default_nettype wire

// *** rsr_top.sv ***
// Reset sequencer and stop-mode recovery with an AHB-Lite register port.
// Assumes internal reset sources and CPU stop signals come from logic on the same clock.
// Summary of operation
// - An external reset low for four clock periods always resets; three may or may not.
// - The device stays in reset while the external reset pin is held low.
// - A pin held low past the time-out releases reset on the fourth clock edge after its release.
// - A reset from the external pin sets outside_pin_reset_flag in reset_cause_register.
// - During an internal or debugger reset, or when configured, the pin is an open-drain low reset output.
// - Power-on, brown-out and watchdog resets also drive the reset pin low.
// - An internal reset drives the pin low until that reset type's delay has elapsed.
// - Setting debug_reset_request starts a power-on style reset that spares the debugger.
// - debug_reset_request clears itself during the reset it started.
// - A debugger reset sets the power-on flag in reset_cause_register.
// - Executing the stop instruction puts the device in the stop state.
// - Stop recovery holds the CPU in reset 66 oscillator cycles, or 5000 with crystal on.
// - Stop recovery changes only reset_cause_register and oscillator_config_register.
// - After stop recovery the internal oscillator is enabled and selected as clock.
`timescale 1ns/10ps
`default_nettype none
module rsr_top #(
    parameter int SMR_SLOW_CYC = rsr_pkg::SMR_SLOW_IPO
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Reset pin, open drain
    input  wire logic        rst_pin_n_in,
    output logic             rst_pin_n_out,
    output logic             rst_pin_oe,
    // Internal reset sources and CPU handshakes
    input  wire logic        power_on_reset,
    input  wire logic        brownout_detect,
    input  wire logic        watchdog_timeout,
    input  wire logic        stop_exec,
    input  wire logic        stop_wake,
    output logic             chip_reset,
    output logic             cpu_reset,
    output logic             stop_mode,
    output logic             ipo_enable,
    output logic             xtal_enable,
    output logic [1:0]       clk_select,
    output logic             irq,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);
    import rsr_pkg::*;

    rsr_state_t         st_ff;
    rsr_state_t         nxt_st;
    logic [CAUSE_W-1:0] cause_ff;
    logic [CAUSE_W-1:0] mask_ff;
    logic [OSC_W-1:0]   osc_ff;
    logic               dbg_req_ff;
    logic               pin_drive_ff;
    logic               internal_ff;
    logic               oe_ff;
    logic [1:0]         oe_hist_ff;
    logic [1:0]         ext_cnt_ff;
    logic               ext_low_ff;
    logic [7:0]         ipo_div_ff;
    logic               ipo_tick_ff;
    logic               chip_reset_ff;
    logic               cpu_reset_ff;
    logic               stop_mode_ff;
    logic               irq_ff;
    logic               wr_pend_ff;
    logic               rd_pend_ff;
    logic [7:0]         addr_ff;
    logic               hreadyout_ff;
    logic [31:0]        hrdata_ff;
    logic               pin_sync;
    logic               pin_quiet;
    logic               int_src;
    logic               any_src;
    logic               dly_busy;
    logic               dly_load;
    logic [12:0]        dly_val;
    logic               dly_tick;
    logic               smr_done;
    logic               bus_take;
    logic               wr_cause;
    logic [CAUSE_W-1:0] cause_set;

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == ADDR_CAUSE) begin
            d[CAUSE_W-1:0] = cause_ff;
        end else if (a == ADDR_MASK) begin
            d[CAUSE_W-1:0] = mask_ff;
        end else if (a == ADDR_DBG) begin
            d[DBG_RST_REQ] = dbg_req_ff;
        end else if (a == ADDR_OSC) begin
            d[OSC_W-1:0] = osc_ff;
        end else if (a == ADDR_PINCFG) begin
            d[PINCFG_DRIVE] = pin_drive_ff;
        end else if (a == ADDR_STATE) begin
            d[1:0] = st_ff;
        end
        return d;
    endfunction

    // External pin capture and glitch filter
    rsr_sync2 u_pin_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (rst_pin_n_in),
        .sync_out (pin_sync)
    );

    // Our own drive shows up on the input after the synchroniser; blank it out
    assign pin_quiet = ~(oe_ff | oe_hist_ff[0] | oe_hist_ff[1]);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_cnt_ff <= 2'h0;
            ext_low_ff <= 1'b0;
        end else if (pin_sync || !pin_quiet) begin
            ext_cnt_ff <= 2'h0;
            ext_low_ff <= 1'b0;
        end else if (ext_cnt_ff != EXT_FILTER_CYC) begin
            ext_cnt_ff <= ext_cnt_ff + 2'h1;
            ext_low_ff <= (ext_cnt_ff + 2'h1) == EXT_FILTER_CYC;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            oe_hist_ff <= 2'h0;
        end else begin
            oe_hist_ff <= {oe_hist_ff[0], oe_ff};
        end
    end

    // Oscillator-rate enable
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ipo_div_ff  <= 8'h00;
            ipo_tick_ff <= 1'b0;
        end else if (ipo_div_ff == IPO_DIV_CYC - 8'h01) begin
            ipo_div_ff  <= 8'h00;
            ipo_tick_ff <= 1'b1;
        end else begin
            ipo_div_ff  <= ipo_div_ff + 8'h01;
            ipo_tick_ff <= 1'b0;
        end
    end

    // Sequencer
    assign int_src = power_on_reset | brownout_detect | watchdog_timeout;
    assign any_src = int_src | dbg_req_ff | ext_low_ff;

    always_comb begin
        nxt_st   = st_ff;
        dly_load = 1'b0;
        dly_val  = RST_TIMEOUT_CYC;
        smr_done = 1'b0;
        case (st_ff)
            RSR_RUN: begin
                if (stop_exec) begin
                    nxt_st = RSR_STOP;
                end
            end
            RSR_STOP: begin
                if (stop_wake) begin
                    nxt_st   = RSR_RECOVER;
                    dly_load = 1'b1;
                    dly_val  = osc_ff[OSC_XTAL_EN] ? 13'(SMR_SLOW_CYC)
                                                   : SMR_FAST_IPO;
                end
            end
            RSR_RECOVER: begin
                if (!dly_busy) begin
                    nxt_st   = RSR_RUN;
                    smr_done = 1'b1;
                end
            end
            RSR_RESET: begin
                // Exit needs the delay over and every source gone
                if (!dly_busy && !ext_low_ff && !int_src) begin
                    nxt_st = RSR_RUN;
                end
            end
            default: nxt_st = RSR_RUN;
        endcase
        if (any_src && (st_ff != RSR_RESET)) begin
            nxt_st   = RSR_RESET;
            dly_load = 1'b1;
            dly_val  = (power_on_reset | brownout_detect | dbg_req_ff) ?
                       POR_DELAY_CYC : RST_TIMEOUT_CYC;
        end
    end

    assign dly_tick = (st_ff == RSR_RECOVER) ? ipo_tick_ff : 1'b1;

    rsr_delay_cnt u_delay (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .load     (dly_load),
        .load_val (dly_val),
        .tick     (dly_tick),
        .busy     (dly_busy)
    );

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff <= RSR_RUN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            internal_ff <= 1'b0;
        end else if (dly_load && (nxt_st == RSR_RESET)) begin
            internal_ff <= int_src | dbg_req_ff;
        end
    end

    // Outputs to the chip; the debugger stays outside chip_reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            chip_reset_ff <= 1'b0;
            cpu_reset_ff  <= 1'b0;
            stop_mode_ff  <= 1'b0;
            oe_ff         <= 1'b0;
        end else begin
            chip_reset_ff <= (nxt_st == RSR_RESET);
            cpu_reset_ff  <= (nxt_st == RSR_RESET) || (nxt_st == RSR_RECOVER);
            stop_mode_ff  <= (nxt_st == RSR_STOP);
            oe_ff         <= ((nxt_st == RSR_RESET) && (dly_load ? (int_src | dbg_req_ff)
                             : (internal_ff && dly_busy))) || pin_drive_ff;
        end
    end

    // AHB-Lite: writes without wait, reads with one wait state
    assign bus_take = hsel && htrans[1] && hready;
    assign wr_cause = wr_pend_ff && (addr_ff == ADDR_CAUSE);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_pend_ff   <= 1'b0;
            rd_pend_ff   <= 1'b0;
            addr_ff      <= 8'h00;
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h0000_0000;
        end else begin
            wr_pend_ff   <= bus_take && hwrite;
            rd_pend_ff   <= bus_take && !hwrite;
            hreadyout_ff <= !(bus_take && !hwrite);
            if (bus_take) begin
                addr_ff <= {haddr[7:2], 2'b00};
            end
            if (rd_pend_ff) begin
                hrdata_ff <= rd_mux(addr_ff);
            end
        end
    end

    // Cause flags: hardware set wins over a write-one clear
    always_comb begin
        cause_set = '0;
        if (dly_load && (nxt_st == RSR_RESET)) begin
            cause_set[CAUSE_POR] = power_on_reset | dbg_req_ff;
            cause_set[CAUSE_EXT] = ext_low_ff;
            cause_set[CAUSE_WDT] = watchdog_timeout;
            cause_set[CAUSE_BO]  = brownout_detect;
        end
        cause_set[CAUSE_SMR] = smr_done;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cause_ff <= CAUSE_RESET;
        end else begin
            cause_ff <= (cause_ff & ~(wr_cause ? hwdata[CAUSE_W-1:0] : '0)) | cause_set;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mask_ff      <= MASK_RESET;
            pin_drive_ff <= 1'b0;
        end else if (wr_pend_ff && (addr_ff == ADDR_MASK)) begin
            mask_ff <= hwdata[CAUSE_W-1:0];
        end else if (wr_pend_ff && (addr_ff == ADDR_PINCFG)) begin
            pin_drive_ff <= hwdata[PINCFG_DRIVE];
        end
    end

    // Request clears once the reset it started is running
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dbg_req_ff <= 1'b0;
        end else if (st_ff == RSR_RESET) begin
            dbg_req_ff <= 1'b0;
        end else if (wr_pend_ff && (addr_ff == ADDR_DBG)) begin
            dbg_req_ff <= hwdata[DBG_RST_REQ];
        end
    end

    // Recovery forces the oscillator choice; other settings keep their values
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            osc_ff <= OSC_RESET;
        end else if (smr_done) begin
            osc_ff[OSC_IPO_EN]                <= 1'b1;
            osc_ff[OSC_SEL_LO+1:OSC_SEL_LO]   <= CLKSEL_IPO;
        end else if (wr_pend_ff && (addr_ff == ADDR_OSC)) begin
            osc_ff <= hwdata[OSC_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(cause_ff & mask_ff);
        end
    end

    assign rst_pin_n_out = 1'b0;
    assign rst_pin_oe    = oe_ff;
    assign chip_reset    = chip_reset_ff;
    assign cpu_reset     = cpu_reset_ff;
    assign stop_mode     = stop_mode_ff;
    assign ipo_enable    = osc_ff[OSC_IPO_EN];
    assign xtal_enable   = osc_ff[OSC_XTAL_EN];
    assign clk_select    = osc_ff[OSC_SEL_LO+1:OSC_SEL_LO];
    assign irq           = irq_ff;
    assign hreadyout     = hreadyout_ff;
    assign hrdata        = hrdata_ff;
    assign hresp         = 1'b0;

endmodule // rsr_top
`default_nettype wire

// *** rsr_top_chk.sv ***
// Port-level checker for the reset and stop-recovery sequencer.
// Assumes it is bound onto rsr_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module rsr_top_chk #(
    parameter int SMR_SLOW_CYC = 5000
) (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       rst_pin_n_in,
    input wire logic       rst_pin_n_out,
    input wire logic       rst_pin_oe,
    input wire logic       power_on_reset,
    input wire logic       brownout_detect,
    input wire logic       watchdog_timeout,
    input wire logic       stop_exec,
    input wire logic       chip_reset,
    input wire logic       cpu_reset,
    input wire logic       stop_mode,
    input wire logic       ipo_enable,
    input wire logic [1:0] clk_select,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp
);
    import rsr_pkg::*;
    logic [11:0] low_ff;
    logic [11:0] oe_ff;
    // Saturating counts of pin-low and own-drive spans
    always_ff @(posedge clock) begin
        if (sys_rst || rst_pin_n_in) low_ff <= 12'h000;
        else if (low_ff != 12'hFFF) low_ff <= low_ff + 12'h001;
    end
    always_ff @(posedge clock) begin
        if (sys_rst || !rst_pin_oe) oe_ff <= 12'h000;
        else if (oe_ff != 12'hFFF) oe_ff <= oe_ff + 12'h001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
    chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    chk_open_drain: assert property (rst_pin_oe |-> !rst_pin_n_out)
        else $error("pin driven high");
    chk_pulse_resets: assert property ((!rst_pin_n_in && !rst_pin_oe)[*4]
        |-> ##[1:7] chip_reset) else $error("low pulse missed");
    chk_pin_holds: assert property ((!rst_pin_n_in && !rst_pin_oe)[*8]
        |-> chip_reset) else $error("left reset with pin low");
    chk_pin_exit: assert property ($rose(rst_pin_n_in) && low_ff > 12'h258
        && !power_on_reset && !brownout_detect |-> ##[1:7] !chip_reset)
        else $error("late exit after pin release");
    chk_src_drive: assert property ($rose(power_on_reset || brownout_detect
        || watchdog_timeout) && !chip_reset |-> ##[1:3] rst_pin_oe)
        else $error("internal reset not driven on pin");
    chk_drive_span: assert property ($fell(rst_pin_oe) |-> oe_ff >= 12'h0F5)
        else $error("pin drive too short");
    chk_cpu_held: assert property (chip_reset |-> cpu_reset)
        else $error("cpu free during chip reset");
    chk_stop_entry: assert property (stop_exec && !cpu_reset && !stop_mode
        && !power_on_reset && !brownout_detect && !watchdog_timeout
        |-> ##[1:2] stop_mode) else $error("stop not entered");
    chk_recover_osc: assert property ($fell(cpu_reset) && !chip_reset
        && !$past(chip_reset) |-> ##[0:2] (ipo_enable && clk_select == CLKSEL_IPO))
        else $error("oscillator not restored");
endmodule // rsr_top_chk
bind rsr_top rsr_top_chk #(.SMR_SLOW_CYC(SMR_SLOW_CYC)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .rst_pin_n_in(rst_pin_n_in),
    .rst_pin_n_out(rst_pin_n_out), .rst_pin_oe(rst_pin_oe),
    .power_on_reset(power_on_reset), .brownout_detect(brownout_detect),
    .watchdog_timeout(watchdog_timeout), .stop_exec(stop_exec),
    .chip_reset(chip_reset), .cpu_reset(cpu_reset), .stop_mode(stop_mode),
    .ipo_enable(ipo_enable), .clk_select(clk_select), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// *** rsr_pin_partner.sv ***
// Board side of the reset pin: external pulse source and pull-up.
// Assumes pulses are started on a clock edge by the bench.
`timescale 1ns/10ps
`default_nettype none
module rsr_pin_partner (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        hold_low,
    input wire logic        pulse_go,
    input wire logic [11:0] pulse_len,
    input wire logic        rst_pin_oe,
    input wire logic        rst_pin_n_out,
    output logic            pin_n
);
    logic [11:0] left_ff;
    always_ff @(posedge clock) begin
        if (sys_rst) left_ff <= 12'h000;
        else if (pulse_go) left_ff <= pulse_len;
        else if (left_ff != 12'h000) left_ff <= left_ff - 12'h001;
    end
    // Wired-AND with a pull-up: low while either party pulls
    assign pin_n = !(rst_pin_oe && !rst_pin_n_out) && !hold_low
                   && (left_ff == 12'h000);
endmodule // rsr_pin_partner
`default_nettype wire

// *** rsr_top_tb.sv ***
// Self-checking bench for the reset and stop-recovery sequencer.
// Assumes the AHB-Lite port is the only slave; hready is its hreadyout.
`timescale 1ns/10ps
`default_nettype none
module rsr_top_tb;
    import rsr_pkg::*;
    localparam int SLOW = 20;
    logic clock, sys_rst, power_on_reset, brownout_detect, watchdog_timeout;
    logic stop_exec, stop_wake, hsel, hwrite, hold_low, pulse_go;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, m, b;
    logic [11:0] pulse_len;
    wire logic pin_n, pin_out, pin_oe, chip_reset, cpu_reset, stop_mode, irq;
    wire logic hreadyout, hresp, ipo_en, xtal_en;
    wire logic [1:0] clk_sel;
    wire logic [31:0] hrdata;
    logic [31:0] exp_q[$];
    logic rd_ph = 1'b0;
    int error_cnt, check_count, seed, n, lo, i;
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    rsr_top #(.SMR_SLOW_CYC(SLOW)) u_dut (.clock(clock), .sys_rst(sys_rst),
        .rst_pin_n_in(pin_n), .rst_pin_n_out(pin_out), .rst_pin_oe(pin_oe),
        .power_on_reset(power_on_reset), .brownout_detect(brownout_detect),
        .watchdog_timeout(watchdog_timeout), .stop_exec(stop_exec),
        .stop_wake(stop_wake), .chip_reset(chip_reset), .cpu_reset(cpu_reset),
        .stop_mode(stop_mode), .ipo_enable(ipo_en), .xtal_enable(xtal_en),
        .clk_select(clk_sel),
        .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp));
    rsr_pin_partner u_pin (.clock(clock), .sys_rst(sys_rst), .hold_low(hold_low),
        .pulse_go(pulse_go), .pulse_len(pulse_len), .rst_pin_oe(pin_oe),
        .rst_pin_n_out(pin_out), .pin_n(pin_n));
    task results;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task cmp_bit(input logic got, input logic want);
        check_count++;
        if (got !== want) begin
            error_cnt++;
            $display("BAD %0t bit %b want %b", $time, got, want);
        end
    endtask
    task cmp_word(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            error_cnt++;
            $display("BAD %0t read %h want %h", $time, got, want);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h000000, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        bus(1'b0, a, 32'h0);
    endtask
    // Waits for chip_reset, or cpu_reset when sel is set, to reach v
    task wait_for(input logic sel, input logic v, output int cyc);
        cyc = 0;
        while ((sel ? cpu_reset : chip_reset) !== v && cyc < 4000) begin
            @(posedge clock);
            cyc++;
        end
        cmp_bit(sel ? cpu_reset : chip_reset, v);
    endtask
    always @(posedge clock) begin
        if (rd_ph && hreadyout === 1'b1) begin
            cmp_word(hrdata, exp_q.pop_front());
            rd_ph = 1'b0;
        end
        if (hsel && htrans[1] && hreadyout && !hwrite) rd_ph = 1'b1;
    end
    initial begin
        #100000;
        error_cnt++;
        results;
    end
    initial begin
        {power_on_reset, brownout_detect, watchdog_timeout, stop_exec} = 4'h0;
        {stop_wake, hsel, hwrite, hold_low, pulse_go} = 5'h00;
        htrans = 2'b00; haddr = 32'h0; hwdata = 32'h0; pulse_len = 12'h000;
        sys_rst = 1'b1; seed = 32'h3fdc;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b1, ADDR_STATE, 32'h3);
        bus(1'b1, 8'h18, 32'hFFFF);
        rd(ADDR_CAUSE, 32'h0);
        rd(ADDR_MASK, 32'h0);
        rd(ADDR_OSC, 32'(OSC_RESET));
        rd(ADDR_STATE, 32'h0);
        rd(8'h18, 32'h0);
        for (i = 0; i < 3; i++) begin
            b = 32'h1 << ((i == 0) ? CAUSE_POR : (i == 1) ? CAUSE_BO : CAUSE_WDT);
            // Force one enabled cause so the interrupt is seen high at least once
            m = ($unsigned($random(seed)) & 32'h1F) | ((i == 1) ? b : 32'h0);
            bus(1'b1, ADDR_MASK, m);
            power_on_reset <= (i == 0); brownout_detect <= (i == 1);
            watchdog_timeout <= (i == 2);
            @(posedge clock);
            {power_on_reset, brownout_detect, watchdog_timeout} <= 3'b000;
            repeat (3) @(posedge clock);
            cmp_bit(pin_oe, 1'b1);
            wait_for(1'b0, 1'b0, n);
            lo = (i == 2) ? int'(RST_TIMEOUT_CYC) : int'(POR_DELAY_CYC);
            cmp_bit(n >= lo - 6 && n <= lo + 6, 1'b1);
            rd(ADDR_CAUSE, b);
            cmp_bit(irq, |(b & m));
            bus(1'b1, ADDR_CAUSE, b);
            repeat (2) @(posedge clock);
            cmp_bit(irq, 1'b0);
        end
        bus(1'b1, ADDR_DBG, 32'h1);
        wait_for(1'b0, 1'b1, n);
        cmp_bit(pin_oe, 1'b1);
        rd(ADDR_DBG, 32'h0);
        wait_for(1'b0, 1'b0, n);
        rd(ADDR_CAUSE, 32'h1 << CAUSE_POR);
        bus(1'b1, ADDR_CAUSE, 32'h1F);
        pulse_go <= 1'b1; pulse_len <= 12'h002;
        @(posedge clock);
        pulse_go <= 1'b0;
        repeat (12) @(posedge clock);
        cmp_bit(chip_reset, 1'b0);
        pulse_go <= 1'b1; pulse_len <= 12'h004;
        @(posedge clock);
        pulse_go <= 1'b0;
        wait_for(1'b0, 1'b1, n);
        cmp_bit(n <= 10, 1'b1);
        wait_for(1'b0, 1'b0, n);
        rd(ADDR_CAUSE, 32'h1 << CAUSE_EXT);
        bus(1'b1, ADDR_CAUSE, 32'h1F);
        hold_low <= 1'b1;
        repeat (700) @(posedge clock);
        cmp_bit(chip_reset, 1'b1);
        hold_low <= 1'b0;
        wait_for(1'b0, 1'b0, n);
        cmp_bit(n <= 7, 1'b1);
        bus(1'b1, ADDR_CAUSE, 32'h1F);
        bus(1'b1, ADDR_PINCFG, 32'h1);
        repeat (300) @(posedge clock);
        cmp_bit(pin_oe, 1'b1);
        cmp_bit(chip_reset, 1'b0);
        bus(1'b1, ADDR_PINCFG, 32'h0);
        repeat (4) @(posedge clock);
        cmp_bit(pin_oe, 1'b0);
        for (i = 0; i < 2; i++) begin
            m = $unsigned($random(seed)) & 32'h0F;
            bus(1'b1, ADDR_MASK, m);
            bus(1'b1, ADDR_OSC, (i == 1) ? 32'hE : 32'hC);
            stop_exec <= 1'b1;
            @(posedge clock);
            stop_exec <= 1'b0;
            repeat (2) @(posedge clock);
            cmp_bit(stop_mode, 1'b1);
            rd(ADDR_STATE, 32'h2);
            stop_wake <= 1'b1;
            @(posedge clock);
            stop_wake <= 1'b0;
            wait_for(1'b1, 1'b1, n);
            wait_for(1'b1, 1'b0, n);
            lo = ((i == 1) ? SLOW : int'(SMR_FAST_IPO)) * int'(IPO_DIV_CYC);
            cmp_bit(n >= lo - int'(IPO_DIV_CYC) && n <= lo + int'(IPO_DIV_CYC), 1'b1);
            rd(ADDR_OSC, (i == 1) ? 32'h3 : 32'h1);
            cmp_bit(xtal_en, i == 1);
            cmp_bit(ipo_en && clk_sel == CLKSEL_IPO, 1'b1);
            rd(ADDR_CAUSE, 32'h1 << CAUSE_SMR);
            rd(ADDR_MASK, m);
            cmp_bit(chip_reset, 1'b0);
            bus(1'b1, ADDR_CAUSE, 32'h1F);
        end
        results;
    end
endmodule // rsr_top_tb
`default_nettype wire
